// File: host_bridge_pkg.sv
// How it works
// R01 - Status bit 14 sets when a system-error message is sent for function zero.
// R02 - Writing 1 to status bit 14 clears it; writing 0 keeps it.
// R03 - Status bit 13 sets on a received master abort; write 1 clears.
// R04 - Status bit 12 sets on a received target abort; write 1 clears.
// R05 - Status bits 11 and 8 read 0 and ignore writes.
// R06 - Status bits 10:9 read 00 and ignore writes.
// R07 - Status bit 7 reads 1 and ignores writes.
// R08 - Status bit 4 reads 1; capability list pointer sits at offset 34h.
// R09 - Latency timer byte at 0Dh reads zero, ignores writes.
// R10 - Header type byte at 0Eh reads zero, has no storage.
// R11 - Sub-class byte is read-only and returns 00h.
// R12 - Base-class byte is read-only and returns 06h.
// R13 - Revision byte is a read-only 8-bit silicon revision.
// R14 - Aperture base bits 31:28 are writable and match upper processor address bits.
// R15 - Aperture base bits 27:22 writable unless masked by size select, then zero.
// R16 - Aperture base bits 21:4 read zero; smallest aperture is 4MB.
// R17 - Aperture base bit 3 reads 1, prefetchable.
// R18 - Aperture base bits 2:0 read zero and ignore writes.
// R19 - Subsystem vendor and identifier reset to zero and take only first write.
// R20 - Capability pointer byte is read-only and returns E4h.
// R21 - Aperture accesses are refused until the aperture enable bit is set.
// R22 - Aperture reads return all bytes, no side effects; writes may merge.
// R23 - No system-error message while the system-error enable bit is 0.
// R24 - Reserved bits read zero and ignore writes.
package host_bridge_pkg;
   // ********************
   // Register offsets
   // ********************
   localparam logic [7:0] OFF_STATUS = 8'h06;
   localparam logic [7:0] OFF_REVISION = 8'h08;
   localparam logic [7:0] OFF_SUB_CLASS = 8'h0A;
   localparam logic [7:0] OFF_BASE_CLASS = 8'h0B;
   localparam logic [7:0] OFF_LATENCY = 8'h0D;
   localparam logic [7:0] OFF_HEADER = 8'h0E;
   localparam logic [7:0] OFF_APERTURE = 8'h10;
   localparam logic [7:0] OFF_SUBSYS_VENDOR = 8'h2C;
   localparam logic [7:0] OFF_SUBSYS_IDENT = 8'h2E;
   localparam logic [7:0] OFF_CAP_POINTER = 8'h34;
   // ********************
   // Field positions
   // ********************
   localparam int SYS_ERR_BIT = 14;
   localparam int RMA_BIT = 13;
   localparam int RTA_BIT = 12;
   localparam int AP_UPPER_LSB = 28;
   localparam int AP_MID_LSB = 22;
   localparam int AP_MID_WIDTH = 6;
   // ********************
   // Values after reset and fixed values
   // ********************
   localparam logic [15:0] STATUS_FIXED = 16'h0090;
   localparam logic [7:0] SUB_CLASS_VALUE = 8'h00;
   localparam logic [7:0] BASE_CLASS_VALUE = 8'h06;
   localparam logic [7:0] LATENCY_VALUE = 8'h00;
   localparam logic [7:0] HEADER_VALUE = 8'h00;
   localparam logic [7:0] CAP_POINTER_VALUE = 8'hE4;
   localparam logic [31:0] APERTURE_RESET = 32'h0000_0008;
   localparam logic [21:0] APERTURE_LOW_FIXED = 22'h00_0008;
   localparam logic [15:0] SUBSYS_RESET = 16'h0000;
   localparam logic [3:0] ALL_BYTES = 4'hF;
   localparam int READ_LATENCY = 1;
endpackage

// File: write_once_if.sv
`timescale 1ns/10ps
interface write_once_if;
   logic [1:0] byteWrite;
   logic [15:0] writeData;
   logic [15:0] value;
   logic locked;
   modport owner(output byteWrite, output writeData, input value, input locked);
   modport field(input byteWrite, input writeData, output value, output locked);
endinterface

// File: write_once_field.sv
`timescale 1ns/10ps
module write_once_field
   import host_bridge_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   write_once_if.field port
);
   logic [15:0] next_value;
   logic anyWrite;

   // ********************
   // Byte lanes
   // ********************
   assign anyWrite = |port.byteWrite;
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane++) begin : g_lane
         assign next_value[lane*8 +: 8] = port.byteWrite[lane] ? port.writeData[lane*8 +: 8]
                                                               : port.value[lane*8 +: 8];
      end
   endgenerate

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.value <= SUBSYS_RESET;
         port.locked <= 1'b0;
      end else if (anyWrite && !port.locked) begin
         port.value <= next_value; // R19
         port.locked <= 1'b1; // R19
      end
   end

   chk_locked_value_stable: assert property (@(posedge clk) disable iff (sys_rst) // R19
      port.locked |=> $stable(port.value) && port.locked)
      else $error("write-once field changed after lock");
endmodule // write_once_field

// File: host_bridge_config_header.sv
`timescale 1ns/10ps
module host_bridge_config_header
   import host_bridge_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWriteData,
   output logic [31:0] cfgReadData,
   output logic cfgReadValid,
   input wire logic errorEvent,
   input wire logic systemErrorMessageEnable,
   output logic systemErrorMessage,
   input wire logic masterAbortIn,
   input wire logic targetAbortIn,
   input wire logic [5:0] apertureSizeSelect,
   input wire logic apertureEnable,
   input wire logic cpuAccess,
   input wire logic cpuWrite,
   input wire logic [31:0] cpuAddr,
   output logic apertureHit,
   output logic apertureRefuse,
   output logic [3:0] apertureReadBytes,
   output logic apertureMergeOk,
   output logic [31:0] apertureBase
);
   // ********************
   // Decode helpers
   // ********************
   function automatic logic isWord(input logic [7:0] addr, input logic [7:0] off);
      isWord = (addr[7:2] == off[7:2]);
   endfunction

   logic systemErrorSignaled;
   logic masterAbortReceived;
   logic targetAbortReceived;
   logic [3:0] apUpper;
   logic [AP_MID_WIDTH-1:0] apMiddle;
   logic [15:0] statusValue;
   logic [31:0] apertureValue;
   logic [31:0] next_readData;
   logic selStatus;
   logic selRevision;
   logic selLatency;
   logic selAperture;
   logic selSubsystem;
   logic selCapPointer;
   logic statusWrite;
   logic apUpperWrite;
   logic apMidHighWrite;
   logic apMidLowWrite;
   logic [AP_MID_WIDTH-1:0] next_apMiddle;
   logic sendMessage;
   logic clearSysErr;
   logic clearRma;
   logic clearRta;
   logic inAperture;
   logic [AP_MID_WIDTH-1:0] midDiff;

   write_once_if vendorPort();
   write_once_if identPort();

   // ********************
   // Address decode
   // ********************
   assign selStatus = isWord(cfgAddr, OFF_STATUS);
   assign selRevision = isWord(cfgAddr, OFF_REVISION);
   assign selLatency = isWord(cfgAddr, OFF_LATENCY);
   assign selAperture = isWord(cfgAddr, OFF_APERTURE);
   assign selSubsystem = isWord(cfgAddr, OFF_SUBSYS_VENDOR);
   assign selCapPointer = isWord(cfgAddr, OFF_CAP_POINTER);

   // ********************
   // Status register
   // ********************
   assign statusWrite = cfgWrite && selStatus && cfgByteEn[3];
   assign clearSysErr = statusWrite && cfgWriteData[16 + SYS_ERR_BIT]; // R02
   assign clearRma = statusWrite && cfgWriteData[16 + RMA_BIT]; // R03
   assign clearRta = statusWrite && cfgWriteData[16 + RTA_BIT]; // R04
   assign sendMessage = errorEvent && systemErrorMessageEnable; // R23

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         systemErrorMessage <= 1'b0;
      end else begin
         systemErrorMessage <= sendMessage; // R23
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         systemErrorSignaled <= 1'b0;
      end else if (sendMessage) begin
         systemErrorSignaled <= 1'b1; // R01
      end else if (clearSysErr) begin
         systemErrorSignaled <= 1'b0; // R02
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         masterAbortReceived <= 1'b0;
      end else if (masterAbortIn) begin
         masterAbortReceived <= 1'b1; // R03
      end else if (clearRma) begin
         masterAbortReceived <= 1'b0; // R03
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         targetAbortReceived <= 1'b0;
      end else if (targetAbortIn) begin
         targetAbortReceived <= 1'b1; // R04
      end else if (clearRta) begin
         targetAbortReceived <= 1'b0; // R04
      end
   end

   // Fixed bits: 11, 10:9, 8 zero, 7 and 4 one, reserved zero
   assign statusValue = STATUS_FIXED // R05 R06 R07 R08 R24
                        | (16'(systemErrorSignaled) << SYS_ERR_BIT)
                        | (16'(masterAbortReceived) << RMA_BIT)
                        | (16'(targetAbortReceived) << RTA_BIT);

   // ********************
   // Aperture base
   // ********************
   assign apUpperWrite = cfgWrite && selAperture && cfgByteEn[3];
   assign apMidHighWrite = cfgWrite && selAperture && cfgByteEn[3];
   assign apMidLowWrite = cfgWrite && selAperture && cfgByteEn[2];
   assign next_apMiddle[5:2] = apMidHighWrite ? cfgWriteData[27:24] : apMiddle[5:2];
   assign next_apMiddle[1:0] = apMidLowWrite ? cfgWriteData[23:22] : apMiddle[1:0];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         apUpper <= APERTURE_RESET[31:AP_UPPER_LSB];
         apMiddle <= APERTURE_RESET[AP_UPPER_LSB-1:AP_MID_LSB];
      end else begin
         if (apUpperWrite) begin
            apUpper <= cfgWriteData[31:AP_UPPER_LSB]; // R14
         end
         apMiddle <= next_apMiddle & ~apertureSizeSelect; // R15
      end
   end

   // Low bits are hardwired: 21:4 zero, 3 prefetchable, 2:0 zero
   assign apertureValue = {apUpper, apMiddle & ~apertureSizeSelect, // R15
                           APERTURE_LOW_FIXED}; // R16 R17 R18

   // ********************
   // Subsystem identifiers
   // ********************
   assign vendorPort.byteWrite = {2{cfgWrite && selSubsystem}} & cfgByteEn[1:0]; // R19
   assign vendorPort.writeData = cfgWriteData[15:0];
   assign identPort.byteWrite = {2{cfgWrite && selSubsystem}} & cfgByteEn[3:2]; // R19
   assign identPort.writeData = cfgWriteData[31:16];

   write_once_field vendorField (
      .clk(clk),
      .sys_rst(sys_rst),
      .port(vendorPort.field)
   );

   write_once_field identField (
      .clk(clk),
      .sys_rst(sys_rst),
      .port(identPort.field)
   );

   // ********************
   // Read path
   // ********************
   always_comb begin
      next_readData = 32'h0000_0000; // R24
      if (selStatus) begin
         next_readData = {statusValue, 16'h0000};
      end else if (selRevision) begin
         next_readData = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, 8'h00, REVISION}; // R11 R12 R13
      end else if (selLatency) begin
         next_readData = {8'h00, HEADER_VALUE, LATENCY_VALUE, 8'h00}; // R09 R10
      end else if (selAperture) begin
         next_readData = apertureValue;
      end else if (selSubsystem) begin
         next_readData = {identPort.value, vendorPort.value};
      end else if (selCapPointer) begin
         next_readData = {24'h00_0000, CAP_POINTER_VALUE}; // R20
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfgReadData <= 32'h0000_0000;
         cfgReadValid <= 1'b0;
      end else begin
         cfgReadValid <= cfgRead;
         if (cfgRead) begin
            cfgReadData <= next_readData;
         end
      end
   end

   // ********************
   // Aperture decode
   // ********************
   assign midDiff = (cpuAddr[AP_UPPER_LSB-1:AP_MID_LSB] ^ apMiddle) & ~apertureSizeSelect;
   assign inAperture = (cpuAddr[31:AP_UPPER_LSB] == apUpper) && (midDiff == 6'h00); // R14 R15

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         apertureHit <= 1'b0;
         apertureRefuse <= 1'b0;
         apertureReadBytes <= 4'h0;
         apertureMergeOk <= 1'b0;
         apertureBase <= APERTURE_RESET;
      end else begin
         apertureHit <= cpuAccess && inAperture && apertureEnable; // R21
         apertureRefuse <= cpuAccess && inAperture && !apertureEnable; // R21
         apertureReadBytes <= (cpuAccess && inAperture && apertureEnable && !cpuWrite) ? ALL_BYTES : 4'h0; // R22
         apertureMergeOk <= cpuAccess && inAperture && apertureEnable && cpuWrite; // R22
         apertureBase <= apertureValue;
      end
   end

   // ********************
   // Assertions
   // ********************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_syserr_on_message: assert property ( // R01
      systemErrorMessage |-> systemErrorSignaled)
      else $error("message sent without flag set");

   chk_syserr_write_clear: assert property ( // R02
      clearSysErr && !sendMessage |=> !systemErrorSignaled)
      else $error("flag not cleared by write of one");

   chk_syserr_zero_keeps: assert property ( // R02
      systemErrorSignaled && !clearSysErr |=> systemErrorSignaled)
      else $error("flag lost without clear");

   chk_master_abort_set: assert property ( // R03
      masterAbortIn |=> masterAbortReceived)
      else $error("master abort not recorded");

   chk_target_abort_set: assert property ( // R04
      targetAbortIn ##1 (!clearRta)[*2] |=> targetAbortReceived)
      else $error("target abort not recorded");

   chk_status_fixed_bits: assert property ( // R05
      cfgRead && selStatus |=> cfgReadValid && cfgReadData[27:23] == 5'b00001 && cfgReadData[20] == 1'b1)
      else $error("status fixed bits wrong");

   chk_class_codes: assert property ( // R12
      cfgRead && selRevision |=> cfgReadData[31:8] == 24'h06_0000)
      else $error("class codes wrong");

   chk_cap_pointer: assert property ( // R20
      cfgRead && selCapPointer |=> cfgReadData == 32'h0000_00E4)
      else $error("capability pointer wrong");

   chk_aperture_low: assert property ( // R16
      cfgRead && selAperture |=> cfgReadData[21:0] == 22'h00_0008)
      else $error("aperture low bits wrong");

   chk_aperture_mask: assert property ( // R15
      cfgRead && selAperture |=> (cfgReadData[27:22] & $past(apertureSizeSelect)) == 6'h00)
      else $error("masked aperture bits not zero");

   chk_aperture_refused: assert property ( // R21
      !apertureEnable |=> !apertureHit && !apertureMergeOk && apertureReadBytes == 4'h0)
      else $error("aperture used while disabled");

   chk_no_message_disabled: assert property ( // R23
      !systemErrorMessageEnable |=> !systemErrorMessage)
      else $error("message sent while disabled");

   chk_syserr_set_wins: assert property ( // R01
      sendMessage |=> systemErrorSignaled)
      else $error("error flag not set by message");

   chk_master_abort_clear: assert property ( // R03
      clearRma && !masterAbortIn |=> !masterAbortReceived)
      else $error("master abort flag not cleared");

   chk_target_abort_clear: assert property ( // R04
      clearRta && !targetAbortIn |=> !targetAbortReceived)
      else $error("target abort flag not cleared");

   chk_select_timing_zero: assert property ( // R06
      cfgRead && selStatus |=> cfgReadData[26:25] == 2'b00)
      else $error("select timing bits not zero");

   chk_back_to_back: assert property ( // R07
      cfgRead && selStatus |=> cfgReadData[23] == 1'b1)
      else $error("back to back bit not one");

   chk_cap_list_bit: assert property ( // R08
      cfgRead && selStatus |=> cfgReadData[20] == 1'b1)
      else $error("capability list bit not one");

   chk_latency_zero: assert property ( // R09
      cfgRead && selLatency |=> cfgReadData[15:8] == 8'h00)
      else $error("latency timer not zero");

   chk_header_zero: assert property ( // R10
      cfgRead && selLatency |=> cfgReadData[23:16] == 8'h00)
      else $error("header type not zero");

   chk_sub_class_zero: assert property ( // R11
      cfgRead && selRevision |=> cfgReadData[23:16] == 8'h00)
      else $error("sub class not zero");

   chk_revision_value: assert property ( // R13
      cfgRead && selRevision |=> cfgReadData[7:0] == REVISION)
      else $error("revision byte wrong");

   chk_aperture_upper_write: assert property ( // R14
      apUpperWrite |=> apUpper == $past(cfgWriteData[31:28]))
      else $error("aperture upper bits not written");

   chk_aperture_prefetch: assert property ( // R17
      cfgRead && selAperture |=> cfgReadData[3] == 1'b1)
      else $error("prefetchable bit not one");

   chk_aperture_type: assert property ( // R18
      cfgRead && selAperture |=> cfgReadData[2:0] == 3'b000)
      else $error("aperture type bits not zero");

   chk_read_bytes_all: assert property ( // R22
      apertureHit && !apertureMergeOk |-> apertureReadBytes == 4'hF)
      else $error("aperture read not all bytes");

   chk_reserved_status_zero: assert property ( // R24
      cfgRead && selStatus |=> cfgReadData[31] == 1'b0 && cfgReadData[22:21] == 2'b00 && cfgReadData[19:0] == 20'h0_0000)
      else $error("reserved status bits not zero");

   cov_syserr_set: cover property (errorEvent && systemErrorMessageEnable ##1 systemErrorSignaled);
   cov_syserr_cleared: cover property (systemErrorSignaled ##1 clearSysErr ##1 !systemErrorSignaled);
   cov_aperture_hit: cover property (apertureHit);
   cov_aperture_refused: cover property (apertureRefuse);
   cov_subsystem_locked: cover property (vendorPort.locked && identPort.locked);
endmodule // host_bridge_config_header

// File: cfg_software_model.sv
`timescale 1ns/10ps
module cfg_software_model (
   input wire logic clk,
   output logic cfgRead,
   output logic cfgWrite,
   output logic [7:0] cfgAddr,
   output logic [3:0] cfgByteEn,
   output logic [31:0] cfgWriteData,
   input wire logic [31:0] cfgReadData,
   input wire logic cfgReadValid
);
   // ***************
   // Idle values
   // ***************
   initial begin
      cfgRead = 1'b0;
      cfgWrite = 1'b0;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWriteData = 32'h0000_0000;
   end
   // ***************
   // Write cycle, one strobe; the subsystem test writes its fields twice
   // ***************
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfgWrite = 1'b1;
      cfgAddr = a;
      cfgByteEn = be;
      cfgWriteData = d;
      @(negedge clk);
      cfgWrite = 1'b0;
      cfgByteEn = 4'h0;
      cfgWriteData = ~d;
   endtask
   // ***************
   // Read cycle, data taken one cycle later
   // ***************
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
      @(negedge clk);
      cfgRead = 1'b1;
      cfgAddr = a;
      @(negedge clk);
      cfgRead = 1'b0;
      cfgAddr = ~a;
      d = cfgReadData;
      v = cfgReadValid;
   endtask
endmodule // cfg_software_model

// File: tb_host_bridge_config_header.sv
`timescale 1ns/10ps
module tb_host_bridge_config_header;
   import host_bridge_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // Arbitrary value
   logic clk, sys_rst, cfgRead, cfgWrite, cfgReadValid, errorEvent, systemErrorMessageEnable;
   logic systemErrorMessage, masterAbortIn, targetAbortIn, apertureEnable, cpuAccess, cpuWrite;
   logic apertureHit, apertureRefuse, apertureMergeOk;
   logic [7:0] cfgAddr;
   logic [3:0] cfgByteEn, apertureReadBytes;
   logic [31:0] cfgWriteData, cfgReadData, cpuAddr, apertureBase;
   logic [5:0] apertureSizeSelect;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   host_bridge_config_header #(.REVISION(REV)) host_bridge_config_header_i (.clk(clk), .sys_rst(sys_rst),
      .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
      .errorEvent(errorEvent), .systemErrorMessageEnable(systemErrorMessageEnable),
      .systemErrorMessage(systemErrorMessage), .masterAbortIn(masterAbortIn), .targetAbortIn(targetAbortIn),
      .apertureSizeSelect(apertureSizeSelect), .apertureEnable(apertureEnable), .cpuAccess(cpuAccess),
      .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .apertureHit(apertureHit), .apertureRefuse(apertureRefuse),
      .apertureReadBytes(apertureReadBytes), .apertureMergeOk(apertureMergeOk), .apertureBase(apertureBase));
   cfg_software_model cfg_software_model_i (.clk(clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
      .cfgReadValid(cfgReadValid));
   // ***************
   // Clock and timeout
   // ***************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ***************
   // Checking helpers
   // ***************
   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] d;
      logic v;
      cfg_software_model_i.rd(a, d, v);
      cmp({31'h0, v}, 32'h1);
      cmp(d & m, exp & m);
   endtask
   task automatic st(input logic [15:0] exp);
      rc(8'h04, {exp, 16'h0000}, 32'hFFFF_0000);
   endtask
   task automatic cpu(input logic en, input logic w, input logic [31:0] a, input logic [6:0] exp);
      @(negedge clk);
      apertureEnable = en;
      cpuAccess = 1'b1;
      cpuWrite = w;
      cpuAddr = a;
      @(negedge clk);
      cpuAccess = 1'b0;
      cmp({25'h0, apertureHit, apertureRefuse, apertureReadBytes, apertureMergeOk}, {25'h0, exp});
   endtask
   // ***************
   // Scenarios
   // ***************
   task automatic t_reset();
      st(16'h0090);
      rc(8'h08, {24'h0600_00, REV}, 32'hFFFF_FFFF);
      rc(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
      rc(8'h10, 32'h0000_0008, 32'hFFFF_FFFF);
      rc(8'h2C, 32'h0000_0000, 32'hFFFF_FFFF);
      rc(8'h34, 32'h0000_00E4, 32'hFFFF_FFFF);
      rc(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
   endtask
   task automatic t_status_ro();
      cfg_software_model_i.wr(8'h04, 4'hC, 32'h8FFF_0000);
      st(16'h0090);
      cfg_software_model_i.wr(8'h04, 4'hC, 32'h0000_0000);
      st(16'h0090);
   endtask
   task automatic t_flags();
      @(negedge clk);
      errorEvent = 1'b1;
      @(negedge clk);
      errorEvent = 1'b0;
      cmp({31'h0, systemErrorMessage}, 32'h0);
      st(16'h0090);
      @(negedge clk);
      systemErrorMessageEnable = 1'b1;
      errorEvent = 1'b1;
      masterAbortIn = 1'b1;
      targetAbortIn = 1'b1;
      @(negedge clk);
      errorEvent = 1'b0;
      masterAbortIn = 1'b0;
      targetAbortIn = 1'b0;
      cmp({31'h0, systemErrorMessage}, 32'h1);
      @(negedge clk);
      cmp({31'h0, systemErrorMessage}, 32'h0);
      st(16'h7090);
      cfg_software_model_i.wr(8'h04, 4'hC, 32'h0000_0000);
      st(16'h7090);
      cfg_software_model_i.wr(8'h04, 4'h8, 32'h2000_0000);
      st(16'h5090);
      cfg_software_model_i.wr(8'h04, 4'h8, 32'h1000_0000);
      st(16'h4090);
      cfg_software_model_i.wr(8'h04, 4'h8, 32'h4000_0000);
      st(16'h0090);
   endtask
   task automatic t_fixed();
      cfg_software_model_i.wr(8'h08, 4'hF, 32'hFFFF_FFFF);
      cfg_software_model_i.wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
      cfg_software_model_i.wr(8'h34, 4'hF, 32'hFFFF_FFFF);
      rc(8'h08, {24'h0600_00, REV}, 32'hFFFF_FFFF);
      rc(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
      rc(8'h34, 32'h0000_00E4, 32'hFFFF_FFFF);
   endtask
   task automatic t_aperture();
      cfg_software_model_i.wr(8'h10, 4'hF, 32'h5A40_0000);
      rc(8'h10, 32'h5A40_0008, 32'hFFFF_FFFF);
      apertureSizeSelect = 6'b000011;
      cfg_software_model_i.wr(8'h10, 4'hF, 32'hFFFF_FFFF);
      rc(8'h10, 32'hFF00_0008, 32'hFFFF_FFFF);
      cmp(apertureBase, 32'hFF00_0008);
      cpu(1'b0, 1'b0, 32'hFFC1_2345, 7'b0100000);
      cpu(1'b1, 1'b0, 32'hFFC1_2345, 7'b1011110);
      cpu(1'b1, 1'b1, 32'hFF00_0000, 7'b1000001);
      cpu(1'b1, 1'b0, 32'hFE00_0000, 7'b0000000);
      cpu(1'b1, 1'b0, 32'hEF00_0000, 7'b0000000);
   endtask
   task automatic t_subsys();
      cfg_software_model_i.wr(8'h2C, 4'hF, 32'h1234_5678);
      rc(8'h2C, 32'h1234_5678, 32'hFFFF_FFFF);
      cfg_software_model_i.wr(8'h2C, 4'hF, 32'hAAAA_BBBB);
      rc(8'h2C, 32'h1234_5678, 32'hFFFF_FFFF);
   endtask
   // ***************
   // Main sequence
   // ***************
   initial begin
      sys_rst = 1'b1;
      errorEvent = 1'b0;
      systemErrorMessageEnable = 1'b0;
      masterAbortIn = 1'b0;
      targetAbortIn = 1'b0;
      apertureSizeSelect = 6'b000000;
      apertureEnable = 1'b0;
      cpuAccess = 1'b0;
      cpuWrite = 1'b0;
      cpuAddr = 32'h0000_0000;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      t_reset();
      t_status_ro();
      t_flags();
      t_fixed();
      t_aperture();
      t_subsys();
      end_of_test();
   end
endmodule // tb_host_bridge_config_header
